// ### dv/ccr_adc_model.sv
// Converter-side stand-in that answers bus voltage measurement requests
`timescale 1ns/100ps
module ccr_adc_model #(
  parameter int         DELAY = 5,
  parameter logic [7:0] VALUE = 8'h5a
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       adc_request,
  output logic            adc_done,
  output logic [7:0]      adc_value
);
  int cnt;
  // Outside the done pulse the code is inverted, so a stale capture cannot match
  assign adc_value = adc_done ? VALUE : ~VALUE;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt      <= 0;
      adc_done <= 1'b0;
    end else begin
      cnt      <= adc_request ? cnt + 1 : 0;
      adc_done <= adc_request && (cnt == DELAY);
    end
  end
endmodule

// ### dv/tb.sv
// Register-level testbench for charger control registers four and five
`timescale 1ns/100ps
module tb;
  logic              mclk, rst, register_reset, watchdog_expired, strap_pin;
  logic              fet_one_fitted, fet_two_fitted, input_fet_drives_off, battery_above_minimum;
  ccr_pkg::ccr_req_t req;
  logic              adc_done, halt_switching, adc_request, input_voltage_limit_update;
  logic [7:0]        adc_value, rdata, input_voltage_limit, out_four, out_five, rd_val;
  logic              f2, f1, rate, stat, hic, boc, ship, ibat, ilim, elim, boc5, seen_halt;
  int                err_total, n_checks, i;

  assign out_four = {f2, f1, rate, stat, hic, 2'h0, boc};
  assign out_five = {ship, 1'b0, ibat, 2'h0, ilim, elim, boc5};

  ccr_regs i_ccr_regs (.mclk(mclk), .rst(rst), .req(req), .register_reset(register_reset),
    .watchdog_expired(watchdog_expired), .strap_pin(strap_pin), .fet_one_fitted(fet_one_fitted),
    .fet_two_fitted(fet_two_fitted), .input_fet_drives_off(input_fet_drives_off),
    .battery_above_minimum(battery_above_minimum), .adc_done(adc_done), .adc_value(adc_value),
    .rdata(rdata), .input_fet_two_drive_on(f2), .input_fet_one_drive_on(f1), .switch_rate_select(rate),
    .status_pin_off(stat), .system_short_hiccup_off(hic), .bus_overcurrent_enable(boc),
    .ship_switch_fitted(ship), .battery_current_out_enable(ibat), .internal_input_limit_enable(ilim),
    .external_limit_pin_enable(elim), .battery_discharge_oc_enable(boc5), .halt_switching(halt_switching),
    .adc_request(adc_request), .input_voltage_limit_update(input_voltage_limit_update),
    .input_voltage_limit(input_voltage_limit));

  ccr_adc_model #(.DELAY(5), .VALUE(8'h5a)) i_ccr_adc_model (.mclk(mclk), .rst(rst),
    .adc_request(adc_request), .adc_done(adc_done), .adc_value(adc_value));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk) req <= '0;
  endtask

  // Read data is registered by the edge that takes the request and lasts one cycle
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk) req <= '0;
    #1 rd_val = rdata;
  endtask

  task automatic pulse_reset();
    @(posedge mclk) rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // Ends just after an edge so that the registered outputs have settled
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  initial begin
    err_total = 0;
    n_checks = 0;
    seen_halt = 1'b0;
    rst = 1'b1;
    req = '0;
    register_reset = 1'b0;
    watchdog_expired = 1'b0;
    strap_pin = 1'b1;
    fet_one_fitted = 1'b1;
    fet_two_fitted = 1'b1;
    input_fet_drives_off = 1'b0;
    battery_above_minimum = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    // First edge after release captures strap and fitted flags, requests follow
    repeat (2) @(posedge mclk);
    rd(8'h13);
    chk("four reset", 8'h21, rd_val);
    rd(8'h14);
    chk("five reset", 8'h16, rd_val);
    rd(8'h15);
    chk("unmapped", 8'h00, rd_val);
    wr(8'h13, 8'hff);
    rd(8'h13);
    chk("four all ones", 8'hf9, rd_val);
    settle();
    chk("four outputs", 8'hf9, out_four);
    @(posedge mclk) input_fet_drives_off <= 1'b1;
    settle();
    rd(8'h13);
    chk("drives off", 8'h39, rd_val);
    chk("drives off outs", 8'h39, out_four);
    wr(8'h14, 8'hff);
    rd(8'h14);
    chk("five all ones", 8'hb7, rd_val);
    settle();
    chk("five outputs", 8'ha7, out_five);
    @(posedge mclk) watchdog_expired <= 1'b1;
    @(posedge mclk) watchdog_expired <= 1'b0;
    rd(8'h13);
    chk("four watchdog", 8'h29, rd_val);
    chk("hiccup kept", 8'h08, rd_val & 8'h08);
    rd(8'h14);
    chk("five watchdog", 8'h96, rd_val);
    wr(8'h14, 8'h01);
    rd(8'h14);
    chk("ship absent lock", 8'h10, rd_val);
    @(posedge mclk) battery_above_minimum <= 1'b1;
    wr(8'h13, 8'h03);
    rd(8'h13);
    chk("detect started", 8'h03, rd_val);
    for (i = 0; i < 50 && input_voltage_limit_update !== 1'b1; i++) begin
      @(posedge mclk);
      #1 if (halt_switching === 1'b1) seen_halt = 1'b1;
    end
    if (i == 50) begin
      err_total++;
      $display("[FAIL] limit update expected 1 seen 0");
      end_of_test();
    end
    #1 chk("halt seen", 8'h01, {7'h0, seen_halt});
    chk("new limit", 8'h5a, input_voltage_limit);
    settle();
    chk("halt released", 8'h00, {7'h0, halt_switching});
    rd(8'h13);
    chk("detect cleared", 8'h01, rd_val);
    @(posedge mclk) battery_above_minimum <= 1'b0;
    wr(8'h13, 8'h0a);
    rd(8'h13);
    chk("detect refused", 8'h08, rd_val);
    @(posedge mclk) register_reset <= 1'b1;
    @(posedge mclk) register_reset <= 1'b0;
    rd(8'h13);
    chk("four reg reset", 8'h21, rd_val);
    rd(8'h14);
    chk("five reg reset", 8'h16, rd_val);
    // A low strap must reach the rate bit on register reset and on power-on
    @(posedge mclk) strap_pin <= 1'b0;
    register_reset <= 1'b1;
    @(posedge mclk) register_reset <= 1'b0;
    rd(8'h13);
    chk("four strap low", 8'h01, rd_val);
    @(posedge mclk) fet_two_fitted <= 1'b0;
    input_fet_drives_off <= 1'b0;
    pulse_reset();
    rd(8'h13);
    chk("four power on strap low", 8'h01, rd_val);
    wr(8'h13, 8'hc0);
    rd(8'h13);
    chk("absent fet lock", 8'h40, rd_val);
    end_of_test();
  end
endmodule

// ### rtl/ccr_detect_seq.sv
// Forced input-voltage-limit detection sequencer
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_detect_seq (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       adc_done,
  input  wire logic [7:0] adc_value,
  output logic            halt_switching,
  output logic            adc_request,
  output logic            limit_update,
  output logic [7:0]      limit_value,
  output logic            done
);
  ccr_pkg::ccr_det_state_t state;
  ccr_pkg::ccr_det_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ccr_pkg::CCR_DET_IDLE:    if (start) next_state = ccr_pkg::CCR_DET_HALT;
      ccr_pkg::CCR_DET_HALT:    next_state = ccr_pkg::CCR_DET_MEASURE;
      ccr_pkg::CCR_DET_MEASURE: if (adc_done) next_state = ccr_pkg::CCR_DET_UPDATE;
      ccr_pkg::CCR_DET_UPDATE:  next_state = ccr_pkg::CCR_DET_IDLE;
      default:                  next_state = ccr_pkg::CCR_DET_IDLE;
    endcase
  end

  // Switching stays halted until the new limit is written, so no input current flows while measuring
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state          <= ccr_pkg::CCR_DET_IDLE;
      halt_switching <= 1'b0;
      adc_request    <= 1'b0;
      limit_update   <= 1'b0;
      limit_value    <= 8'h00;
      done           <= 1'b0;
    end else begin
      state          <= next_state;
      halt_switching <= (next_state != ccr_pkg::CCR_DET_IDLE);
      adc_request    <= (next_state == ccr_pkg::CCR_DET_MEASURE);
      limit_update   <= (state == ccr_pkg::CCR_DET_MEASURE) && adc_done;
      if ((state == ccr_pkg::CCR_DET_MEASURE) && adc_done) begin
        limit_value <= adc_value;
      end
      done           <= (state == ccr_pkg::CCR_DET_UPDATE);
    end
  end

  measure_after_halt_a: assert property (@(posedge mclk) disable iff (rst)
    (state == ccr_pkg::CCR_DET_HALT) |=> adc_request && halt_switching)
    else $error("measurement did not follow halt");

  update_holds_halt_a: assert property (@(posedge mclk) disable iff (rst)
    limit_update |-> halt_switching)
    else $error("limit updated without halted switching");
endmodule

// ### rtl/ccr_params.svh
// Offsets, field positions and reset values of the charger control registers four and five
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_OFS_CTRL_FOUR      8'h13
`define CCR_OFS_CTRL_FIVE      8'h14
`define CCR_BIT_FET_TWO        7
`define CCR_BIT_FET_ONE        6
`define CCR_BIT_RATE           5
`define CCR_BIT_STAT_OFF       4
`define CCR_BIT_HICCUP_OFF     3
`define CCR_BIT_FORCE_DET      1
`define CCR_BIT_BUS_OC         0
`define CCR_BIT_SHIP_FITTED    7
`define CCR_BIT_IBAT_OUT       5
`define CCR_BIT_INT_LIMIT      2
`define CCR_BIT_EXT_LIMIT      1
`define CCR_BIT_BAT_OC         0
`define CCR_RST_FOUR_FIXED     8'h01
`define CCR_RST_FIVE           8'h16
`define CCR_FIVE_RSVD_VALUE    2'h2
`define CCR_WR_MASK_FOUR       8'hfb
`define CCR_WR_MASK_FIVE       8'ha7
`endif

// ### rtl/ccr_pkg.sv
// Types shared by the charger control register bank
package ccr_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_req_t;

  typedef enum logic [1:0] {
    CCR_DET_IDLE    = 2'b00,
    CCR_DET_HALT    = 2'b01,
    CCR_DET_MEASURE = 2'b10,
    CCR_DET_UPDATE  = 2'b11
  } ccr_det_state_t;
endpackage

// ### rtl/ccr_regs.sv
// Charger control registers four and five with their side effects
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_regs (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire ccr_pkg::ccr_req_t req,
  input  wire logic              register_reset,
  input  wire logic              watchdog_expired,
  input  wire logic              strap_pin,
  input  wire logic              fet_one_fitted,
  input  wire logic              fet_two_fitted,
  input  wire logic              input_fet_drives_off,
  input  wire logic              battery_above_minimum,
  input  wire logic              adc_done,
  input  wire logic [7:0]        adc_value,
  output logic [7:0]             rdata,
  output logic                   input_fet_two_drive_on,
  output logic                   input_fet_one_drive_on,
  output logic                   switch_rate_select,
  output logic                   status_pin_off,
  output logic                   system_short_hiccup_off,
  output logic                   bus_overcurrent_enable,
  output logic                   ship_switch_fitted,
  output logic                   battery_current_out_enable,
  output logic                   internal_input_limit_enable,
  output logic                   external_limit_pin_enable,
  output logic                   battery_discharge_oc_enable,
  output logic                   halt_switching,
  output logic                   adc_request,
  output logic                   input_voltage_limit_update,
  output logic [7:0]             input_voltage_limit
);
  logic [7:0] ctrl_four;
  logic [7:0] ctrl_five;
  logic       strap_taken;
  logic       fet_one_ok;
  logic       fet_two_ok;
  logic       detect_done;
  logic       ship_fitted_q;

  // Fitted flags and strap are caught by a clocked process after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_taken <= 1'b0;
      fet_one_ok  <= 1'b0;
      fet_two_ok  <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      fet_one_ok  <= fet_one_fitted;
      fet_two_ok  <= fet_two_fitted;
    end
  end

  wire wr_four = req.wr && (req.addr == `CCR_OFS_CTRL_FOUR);
  wire wr_five = req.wr && (req.addr == `CCR_OFS_CTRL_FIVE);
  wire rd_four = req.rd && (req.addr == `CCR_OFS_CTRL_FOUR);
  wire rd_five = req.rd && (req.addr == `CCR_OFS_CTRL_FIVE);

  wire [7:0] wd = req.wdata;
  wire       ship_next = wr_five ? wd[`CCR_BIT_SHIP_FITTED] : ctrl_five[`CCR_BIT_SHIP_FITTED];

  wire next_fet_two = wd[`CCR_BIT_FET_TWO] && fet_two_ok && !input_fet_drives_off;
  wire next_fet_one = wd[`CCR_BIT_FET_ONE] && fet_one_ok && !input_fet_drives_off;
  wire force_ok     = wd[`CCR_BIT_FORCE_DET] && battery_above_minimum;
  wire start_det    = wr_four && force_ok && !ctrl_four[`CCR_BIT_FORCE_DET];
  wire next_bat_oc  = wd[`CCR_BIT_BAT_OC] && wd[`CCR_BIT_SHIP_FITTED];

  wire [7:0] four_fixed_rst = `CCR_RST_FOUR_FIXED;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_four <= `CCR_RST_FOUR_FIXED;
    end else if (register_reset) begin
      ctrl_four <= four_fixed_rst;
      ctrl_four[`CCR_BIT_RATE] <= strap_pin;
    end else if (!strap_taken) begin
      ctrl_four[`CCR_BIT_RATE] <= strap_pin;
    end else begin
      if (wr_four) begin
        ctrl_four[`CCR_BIT_FET_TWO]    <= next_fet_two;
        ctrl_four[`CCR_BIT_FET_ONE]    <= next_fet_one;
        ctrl_four[`CCR_BIT_RATE]       <= wd[`CCR_BIT_RATE];
        ctrl_four[`CCR_BIT_STAT_OFF]   <= wd[`CCR_BIT_STAT_OFF];
        ctrl_four[`CCR_BIT_HICCUP_OFF] <= wd[`CCR_BIT_HICCUP_OFF];
        ctrl_four[`CCR_BIT_BUS_OC]     <= wd[`CCR_BIT_BUS_OC];
      end
      if (input_fet_drives_off) begin
        ctrl_four[`CCR_BIT_FET_TWO] <= 1'b0;
        ctrl_four[`CCR_BIT_FET_ONE] <= 1'b0;
      end
      if (watchdog_expired) begin
        ctrl_four[`CCR_BIT_STAT_OFF] <= 1'b0;
      end
      // Start wins over completion; the sequencer cannot finish in its first cycle anyway
      if (start_det) begin
        ctrl_four[`CCR_BIT_FORCE_DET] <= 1'b1;
      end else if (detect_done) begin
        ctrl_four[`CCR_BIT_FORCE_DET] <= 1'b0;
      end
      ctrl_four[2] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_five <= `CCR_RST_FIVE;
    end else if (register_reset) begin
      ctrl_five <= `CCR_RST_FIVE;
    end else begin
      if (wr_five) begin
        ctrl_five[`CCR_BIT_SHIP_FITTED] <= wd[`CCR_BIT_SHIP_FITTED];
        ctrl_five[`CCR_BIT_IBAT_OUT]    <= wd[`CCR_BIT_IBAT_OUT];
        ctrl_five[`CCR_BIT_INT_LIMIT]   <= wd[`CCR_BIT_INT_LIMIT];
        ctrl_five[`CCR_BIT_EXT_LIMIT]   <= wd[`CCR_BIT_EXT_LIMIT];
        ctrl_five[`CCR_BIT_BAT_OC]      <= next_bat_oc;
      end
      if (watchdog_expired) begin
        ctrl_five[`CCR_BIT_IBAT_OUT]  <= 1'b0;
        ctrl_five[`CCR_BIT_INT_LIMIT] <= 1'b1;
        ctrl_five[`CCR_BIT_BAT_OC]    <= 1'b0;
      end
      if (!ship_next) begin
        ctrl_five[`CCR_BIT_BAT_OC] <= 1'b0;
      end
      ctrl_five[6]   <= 1'b0;
      ctrl_five[4:3] <= `CCR_FIVE_RSVD_VALUE;
    end
  end

  ccr_detect_seq u_detect (
    .mclk           (mclk),
    .rst            (rst),
    .start          (start_det),
    .adc_done       (adc_done),
    .adc_value      (adc_value),
    .halt_switching (halt_switching),
    .adc_request    (adc_request),
    .limit_update   (input_voltage_limit_update),
    .limit_value    (input_voltage_limit),
    .done           (detect_done)
  );

  wire [7:0] read_mux = rd_four ? ctrl_four : (rd_five ? ctrl_five : 8'h00);

  // Outputs are registered copies, one cycle behind the register bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata                       <= 8'h00;
      input_fet_two_drive_on      <= 1'b0;
      input_fet_one_drive_on      <= 1'b0;
      switch_rate_select          <= 1'b0;
      status_pin_off              <= 1'b0;
      system_short_hiccup_off     <= 1'b0;
      bus_overcurrent_enable      <= 1'b1;
      ship_fitted_q               <= 1'b0;
      battery_current_out_enable  <= 1'b0;
      internal_input_limit_enable <= 1'b1;
      external_limit_pin_enable   <= 1'b1;
      battery_discharge_oc_enable <= 1'b0;
    end else begin
      rdata                       <= read_mux;
      input_fet_two_drive_on      <= ctrl_four[`CCR_BIT_FET_TWO];
      input_fet_one_drive_on      <= ctrl_four[`CCR_BIT_FET_ONE];
      switch_rate_select          <= ctrl_four[`CCR_BIT_RATE];
      status_pin_off              <= ctrl_four[`CCR_BIT_STAT_OFF];
      system_short_hiccup_off     <= ctrl_four[`CCR_BIT_HICCUP_OFF];
      bus_overcurrent_enable      <= ctrl_four[`CCR_BIT_BUS_OC];
      ship_fitted_q               <= ctrl_five[`CCR_BIT_SHIP_FITTED];
      battery_current_out_enable  <= ctrl_five[`CCR_BIT_IBAT_OUT];
      internal_input_limit_enable <= ctrl_five[`CCR_BIT_INT_LIMIT];
      external_limit_pin_enable   <= ctrl_five[`CCR_BIT_EXT_LIMIT];
      battery_discharge_oc_enable <= ctrl_five[`CCR_BIT_BAT_OC];
    end
  end
  assign ship_switch_fitted = ship_fitted_q;

  sequence drives_forced_s;
    input_fet_drives_off ##1 1'b1;
  endsequence

  fet_two_lock_a: assert property (@(posedge mclk) disable iff (rst)
    (strap_taken && !fet_two_ok) |-> !ctrl_four[`CCR_BIT_FET_TWO])
    else $error("absent second FET drive set");

  fet_one_lock_a: assert property (@(posedge mclk) disable iff (rst)
    (strap_taken && !fet_one_ok) |-> !ctrl_four[`CCR_BIT_FET_ONE])
    else $error("absent first FET drive set");

  strap_rate_a: assert property (@(posedge mclk) disable iff (rst)
    (register_reset && !wr_four) |=> ctrl_four[`CCR_BIT_RATE] == $past(strap_pin))
    else $error("rate bit not taken from strap");

  stat_watchdog_a: assert property (@(posedge mclk) disable iff (rst)
    watchdog_expired |=> !ctrl_four[`CCR_BIT_STAT_OFF] ##1 !status_pin_off)
    else $error("status off survived watchdog");

  hiccup_keep_a: assert property (@(posedge mclk) disable iff (rst)
    (watchdog_expired && !register_reset && !wr_four) |=> $stable(ctrl_four[`CCR_BIT_HICCUP_OFF]))
    else $error("hiccup bit changed by watchdog");

  force_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_four && !battery_above_minimum && !ctrl_four[`CCR_BIT_FORCE_DET] && !register_reset)
    |=> !ctrl_four[`CCR_BIT_FORCE_DET])
    else $error("force detect accepted at low battery");

  bus_oc_reset_a: assert property (@(posedge mclk) disable iff (rst)
    register_reset |=> ctrl_four[`CCR_BIT_BUS_OC] ##1 bus_overcurrent_enable)
    else $error("bus overcurrent enable not restored");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_four[2] and (rd_four |=> !rdata[2]))
    else $error("reserved bit not zero");

  five_reserved_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl_five[6] == 1'b0 && ctrl_five[4:3] == 2'h2)
    else $error("register five reserved bits wrong");

  ship_lock_a: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_five[`CCR_BIT_SHIP_FITTED] |-> !ctrl_five[`CCR_BIT_BAT_OC])
    else $error("battery oc set without ship switch");

  drives_off_a: assert property (@(posedge mclk) disable iff (rst)
    drives_forced_s |-> ctrl_four[7:6] == 2'b00)
    else $error("FET drives not forced off");
endmodule
